// ===== rtc_trim_dst_pkg.sv
// shared constants and carrier types for the trim, mains check and summer-time block
package rtc_trim_dst_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_FINE_TRIM     = 8'h14;
    localparam logic [7:0] ADDR_START_MONTH   = 8'h15;
    localparam logic [7:0] ADDR_START_WEEKDAY = 8'h16;
    localparam logic [7:0] ADDR_START_DATE    = 8'h17;
    localparam logic [7:0] ADDR_START_HOUR    = 8'h18;
    localparam logic [7:0] ADDR_END_MONTH     = 8'h19;
    localparam logic [7:0] ADDR_END_WEEKDAY   = 8'h1a;
    localparam logic [7:0] ADDR_END_DATE      = 8'h1b;
    localparam logic [7:0] ADDR_END_HOUR      = 8'h1c;

    // values after reset
    localparam logic [7:0] RESET_FINE_TRIM     = 8'h00;
    localparam logic [7:0] RESET_START_MONTH   = 8'h04;
    localparam logic [7:0] RESET_START_WEEKDAY = 8'h00;
    localparam logic [7:0] RESET_START_DATE    = 8'h01;
    localparam logic [7:0] RESET_START_HOUR    = 8'h02;
    localparam logic [7:0] RESET_END_MONTH     = 8'h10;
    localparam logic [7:0] RESET_END_WEEKDAY   = 8'h00;
    localparam logic [7:0] RESET_END_DATE      = 8'h01;
    localparam logic [7:0] RESET_END_HOUR      = 8'h02;

    // writable bits of each register; the rest read as zero
    localparam logic [7:0] MASK_FINE_TRIM = 8'h1f;
    localparam logic [7:0] MASK_MONTH     = 8'h1f;
    localparam logic [7:0] MASK_START_MON = 8'h9f;
    localparam logic [7:0] MASK_WEEKDAY   = 8'h7f;
    localparam logic [7:0] MASK_DATE      = 8'h3f;
    localparam logic [7:0] MASK_HOUR      = 8'hbf;

    // field positions
    localparam int MIN_LEVEL_BIT      = 4;
    localparam int ENABLE_BIT         = 7;
    localparam int PRIORITY_BIT       = 6;
    localparam int WEEK_LSB           = 3;
    localparam int FORMAT_BIT         = 7;

    // crystal counts: one second and a 10 ppm step (one count per 100000)
    localparam logic [14:0] XTAL_PER_SECOND = 15'h7fff;
    localparam int          PPM_STEP_COUNTS = 100000;

    // expected crystal counts for each qualification length
    localparam logic [13:0] EXPECT_60_1  = 14'h0222;   // 546
    localparam logic [13:0] EXPECT_60_6  = 14'h0ccd;   // 3277
    localparam logic [13:0] EXPECT_60_12 = 14'h199a;   // 6554
    localparam logic [13:0] EXPECT_50_1  = 14'h028f;   // 655
    localparam logic [13:0] EXPECT_50_5  = 14'h0ccd;   // 3277
    localparam logic [13:0] EXPECT_50_10 = 14'h199a;   // 6554

    typedef struct packed {
        logic [7:0] month;
        logic [7:0] date;
        logic [2:0] weekday;
        logic [7:0] hour;
    } rtc_time_type;

    typedef struct packed {
        logic [7:0] month;
        logic [7:0] weekday;
        logic [7:0] date;
        logic [7:0] hour;
    } dst_setting_type;

endpackage

// ===== mains_qual_checker.sv
// counts crystal cycles across a chosen number of mains cycles and judges the error
`timescale 1ns/1ps
module mains_qual_checker
    import rtc_trim_dst_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       xtal_tick,
    input  wire logic       ac_rise,
    input  wire logic [1:0] mains_qual_period_select,
    input  wire logic       line_freq_select,
    input  wire logic [1:0] mains_error_budget_select,
    output logic            mains_qual_fail,
    output logic            qual_done
);
    logic [3:0]  cycles_wanted;
    logic [13:0] expected;
    logic [4:0]  budget;
    logic [3:0]  cycles_seen;
    logic [14:0] xtal_count;
    logic        counting;
    logic [14:0] deviation;

    always_comb begin
        case (mains_qual_period_select)
            2'b01:   cycles_wanted = 4'd1;
            2'b10:   cycles_wanted = line_freq_select ? 4'd5 : 4'd6;
            default: cycles_wanted = line_freq_select ? 4'd10 : 4'd12;
        endcase
        case (mains_qual_period_select)
            2'b01:   expected = line_freq_select ? EXPECT_50_1 : EXPECT_60_1;
            2'b10:   expected = line_freq_select ? EXPECT_50_5 : EXPECT_60_6;
            default: expected = line_freq_select ? EXPECT_50_10 : EXPECT_60_12;
        endcase
        case (mains_error_budget_select)
            2'b00:   budget = {1'b0, cycles_wanted};
            2'b01:   budget = {cycles_wanted, 1'b0};
            2'b10:   budget = 5'd1;
            default: budget = 5'd2;
        endcase
        if (xtal_count > {1'b0, expected}) begin
            deviation = xtal_count - {1'b0, expected};
        end else begin
            deviation = {1'b0, expected} - xtal_count;
        end
    end

    // the window is framed by mains edges, so the first edge only opens it
    always_ff @(posedge clk_sys) begin
        if (reset || mains_qual_period_select == 2'b00) begin
            counting    <= 1'b0;
            cycles_seen <= 4'd0;
            xtal_count  <= 15'd0;
        end else if (ac_rise) begin
            counting <= 1'b1;
            if (counting && cycles_seen + 4'd1 == cycles_wanted) begin
                cycles_seen <= 4'd0;
                xtal_count  <= {14'd0, xtal_tick};
            end else begin
                cycles_seen <= counting ? cycles_seen + 4'd1 : 4'd0;
                xtal_count  <= counting ? xtal_count + {14'd0, xtal_tick}
                                        : {14'd0, xtal_tick};
            end
        end else if (counting && xtal_tick && xtal_count != 15'h7fff) begin
            xtal_count <= xtal_count + 15'd1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || mains_qual_period_select == 2'b00) begin
            mains_qual_fail <= 1'b0;
            qual_done       <= 1'b0;
        end else begin
            qual_done <= 1'b0;
            if (ac_rise && counting && cycles_seen + 4'd1 == cycles_wanted) begin
                mains_qual_fail <= deviation > {10'd0, budget};
                qual_done       <= 1'b1;
            end
        end
    end
endmodule // mains_qual_checker

// ===== dst_match.sv
// compares the running calendar with one summer-time switch setting
`timescale 1ns/1ps
module dst_match
    import rtc_trim_dst_pkg::*;
(
    input  wire rtc_time_type    now,
    input  wire dst_setting_type setting,
    output logic                 hit
);
    logic [5:0] date_bin;
    logic [2:0] occurrence;
    logic       day_ok;

    always_comb begin
        date_bin   = 6'(now.date[5:4]) * 6'd10 + {2'b00, now.date[3:0]};
        occurrence = 3'((date_bin - 6'd1) / 6'd7) + 3'd1;
        if (setting.weekday[PRIORITY_BIT]) begin
            day_ok = (now.weekday == setting.weekday[2:0])
                   && (occurrence == setting.weekday[5:WEEK_LSB]);
        end else begin
            day_ok = now.date == setting.date;
        end
        // a format mismatch never matches, so the jump cannot happen
        hit = (now.month == setting.month) && day_ok
            && (now.hour == setting.hour);
    end
endmodule // dst_match

// ===== rtc_trim_dst_control.sv
// crystal trim, mains qualification and summer-time switching for the clock core
// Operation
// - budget codes 00/01 allow one or two counts per counted mains cycle
// - budget codes 10/11 allow one or two counts in total
// - pass only when count deviation stays within the chosen budget
// - level select bit picks 5% or 10% of supply threshold
// - trim codes 0001 to 0110 give +10 to +60 ppm
// - codes 1001 to 1110 give -10 to -60 ppm; others no change
// - summer-time enable bit seven of start month, cleared at power-up
// - start month field, default April 04h
// - start weekday 0 to 6, default Sunday; priority bit selects weekday match
// - start date used only without weekday priority, default 01h
// - start hour carries format bit, default 02h, jumps two to three
// - end month field, default October 10h
// - end weekday 0 to 6, default Sunday; priority bit selects weekday match
// - end date used only without weekday priority, default first day
// - end match steps the clock back two to one
// - eight consecutive bytes hold start then end settings
// - period select counts 1/6/12 or 1/5/10 mains cycles, 00 off
// - count outside allowed window sets the mains failure flag
`timescale 1ns/1ps
module rtc_trim_dst_control
    import rtc_trim_dst_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // register port from the serial interface
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic [7:0]      reg_rdata,
    // loose bits held by the neighbouring mains register
    input  wire logic [1:0] mains_error_budget_select,
    input  wire logic [1:0] mains_qual_period_select,
    input  wire logic       line_freq_select,
    // pins
    input  wire logic       xtal_clk_pin,
    input  wire logic       ac_in_pin,
    // calendar from the clock core
    input  wire rtc_time_type now,
    input  wire logic       hour_rollover,
    // outputs
    output logic            mains_min_level_select,
    output logic            mains_qual_fail,
    output logic            qual_done,
    output logic            second_tick,
    output logic            dst_step_forward,
    output logic            dst_step_back
);
    logic [7:0]      fine_trim_and_ac_level;
    logic [7:0]      summer_start_month_reg;
    logic [7:0]      summer_start_weekday_reg;
    logic [7:0]      summer_start_date_reg;
    logic [7:0]      summer_start_hour_reg;
    logic [7:0]      summer_end_month_reg;
    logic [7:0]      summer_end_weekday_reg;
    logic [7:0]      summer_end_date_reg;
    logic [7:0]      summer_end_hour_reg;

    logic [1:0]      xtal_sync;
    logic [1:0]      ac_sync;
    logic            xtal_last;
    logic            ac_last;
    logic            xtal_tick;
    logic            ac_rise;

    logic [3:0]      crystal_digital_trim;
    logic [2:0]      trim_magnitude;
    logic            trim_slow_down;
    logic [16:0]     trim_interval;
    logic [16:0]     trim_count;
    logic            trim_due;
    logic            trim_pending;
    logic [14:0]     second_divider;
    logic [14:0]     next_second_divider;
    logic            second_wrap;

    dst_setting_type start_setting;
    dst_setting_type end_setting;
    logic            start_hit;
    logic            end_hit;
    logic            start_done;
    logic            end_done;
    logic            start_fire;
    logic            end_fire;
    logic            summer_time_enable;
    logic [7:0]      next_rdata;

    // register file; the eight summer-time bytes sit back to back after trim
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fine_trim_and_ac_level   <= RESET_FINE_TRIM;
            summer_start_month_reg   <= RESET_START_MONTH;
            summer_start_weekday_reg <= RESET_START_WEEKDAY;
            summer_start_date_reg    <= RESET_START_DATE;
            summer_start_hour_reg    <= RESET_START_HOUR;
            summer_end_month_reg     <= RESET_END_MONTH;
            summer_end_weekday_reg   <= RESET_END_WEEKDAY;
            summer_end_date_reg      <= RESET_END_DATE;
            summer_end_hour_reg      <= RESET_END_HOUR;
        end else if (reg_write) begin
            if (reg_addr == ADDR_FINE_TRIM) begin
                fine_trim_and_ac_level <= reg_wdata & MASK_FINE_TRIM;
            end else if (reg_addr == ADDR_START_MONTH) begin
                summer_start_month_reg <= reg_wdata & MASK_START_MON;
            end else if (reg_addr == ADDR_START_WEEKDAY) begin
                summer_start_weekday_reg <= reg_wdata & MASK_WEEKDAY;
            end else if (reg_addr == ADDR_START_DATE) begin
                summer_start_date_reg <= reg_wdata & MASK_DATE;
            end else if (reg_addr == ADDR_START_HOUR) begin
                summer_start_hour_reg <= reg_wdata & MASK_HOUR;
            end else if (reg_addr == ADDR_END_MONTH) begin
                summer_end_month_reg <= reg_wdata & MASK_MONTH;
            end else if (reg_addr == ADDR_END_WEEKDAY) begin
                summer_end_weekday_reg <= reg_wdata & MASK_WEEKDAY;
            end else if (reg_addr == ADDR_END_DATE) begin
                summer_end_date_reg <= reg_wdata & MASK_DATE;
            end else if (reg_addr == ADDR_END_HOUR) begin
                summer_end_hour_reg <= reg_wdata & MASK_HOUR;
            end
        end
    end

    always_comb begin
        if (reg_addr == ADDR_FINE_TRIM) begin
            next_rdata = fine_trim_and_ac_level;
        end else if (reg_addr == ADDR_START_MONTH) begin
            next_rdata = summer_start_month_reg;
        end else if (reg_addr == ADDR_START_WEEKDAY) begin
            next_rdata = summer_start_weekday_reg;
        end else if (reg_addr == ADDR_START_DATE) begin
            next_rdata = summer_start_date_reg;
        end else if (reg_addr == ADDR_START_HOUR) begin
            next_rdata = summer_start_hour_reg;
        end else if (reg_addr == ADDR_END_MONTH) begin
            next_rdata = summer_end_month_reg;
        end else if (reg_addr == ADDR_END_WEEKDAY) begin
            next_rdata = summer_end_weekday_reg;
        end else if (reg_addr == ADDR_END_DATE) begin
            next_rdata = summer_end_date_reg;
        end else if (reg_addr == ADDR_END_HOUR) begin
            next_rdata = summer_end_hour_reg;
        end else begin
            next_rdata = 8'h00;
        end
    end

    // read data holds until the next read
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mains_min_level_select <= 1'b0;
        end else begin
            mains_min_level_select <= fine_trim_and_ac_level[MIN_LEVEL_BIT];
        end
    end

    // pins cross into the system clock through two flops before edge detection
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            xtal_sync <= 2'b00;
            xtal_last <= 1'b0;
        end else begin
            xtal_sync <= {xtal_sync[0], xtal_clk_pin};
            xtal_last <= xtal_sync[1];
        end
    end

    // same two-flop path for mains so both edges keep equal latency
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ac_sync <= 2'b00;
            ac_last <= 1'b0;
        end else begin
            ac_sync <= {ac_sync[0], ac_in_pin};
            ac_last <= ac_sync[1];
        end
    end

    assign xtal_tick = xtal_sync[1] && !xtal_last;
    assign ac_rise   = ac_sync[1] && !ac_last;

    mains_qual_checker qual (
        .clk_sys                  (clk_sys),
        .reset                    (reset),
        .xtal_tick                (xtal_tick),
        .ac_rise                  (ac_rise),
        .mains_qual_period_select (mains_qual_period_select),
        .line_freq_select         (line_freq_select),
        .mains_error_budget_select(mains_error_budget_select),
        .mains_qual_fail          (mains_qual_fail),
        .qual_done                (qual_done)
    );

    // trim decode: magnitude in 10 ppm steps and its direction
    // low bits 000 and 111 mean no correction in either direction
    assign crystal_digital_trim = fine_trim_and_ac_level[3:0];

    always_comb begin
        trim_slow_down = crystal_digital_trim[3];
        if (crystal_digital_trim[2:0] == 3'b000 || crystal_digital_trim[2:0] == 3'b111) begin
            trim_magnitude = 3'd0;
        end else begin
            trim_magnitude = crystal_digital_trim[2:0];
        end
        case (trim_magnitude)
            3'd1:    trim_interval = 17'(PPM_STEP_COUNTS / 1);
            3'd2:    trim_interval = 17'(PPM_STEP_COUNTS / 2);
            3'd3:    trim_interval = 17'(PPM_STEP_COUNTS / 3);
            3'd4:    trim_interval = 17'(PPM_STEP_COUNTS / 4);
            3'd5:    trim_interval = 17'(PPM_STEP_COUNTS / 5);
            default: trim_interval = 17'(PPM_STEP_COUNTS / 6);
        endcase
    end

    // the correction interval restarts whenever it is reached
    always_ff @(posedge clk_sys) begin
        if (reset || trim_magnitude == 3'd0) begin
            trim_count <= 17'd0;
            trim_due   <= 1'b0;
        end else begin
            trim_due <= 1'b0;
            if (xtal_tick && trim_count + 17'd1 >= trim_interval) begin
                trim_count <= 17'd0;
                trim_due   <= 1'b1;
            end else if (xtal_tick) begin
                trim_count <= trim_count + 17'd1;
            end
        end
    end

    // faster clock skips one count, slower clock swallows one count
    // a correction landing on the wrap count is lost for that second
    always_comb begin
        next_second_divider = second_divider;
        second_wrap         = 1'b0;
        if (xtal_tick) begin
            if (trim_pending && trim_slow_down) begin
                next_second_divider = second_divider;
            end else if (trim_pending) begin
                next_second_divider = second_divider + 15'd2;
            end else begin
                next_second_divider = second_divider + 15'd1;
            end
            if (second_divider == XTAL_PER_SECOND
                || (trim_pending && !trim_slow_down
                    && second_divider == XTAL_PER_SECOND - 15'd1)) begin
                second_wrap         = 1'b1;
                next_second_divider = 15'd0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            second_divider <= 15'd0;
            second_tick    <= 1'b0;
        end else begin
            second_divider <= next_second_divider;
            second_tick    <= second_wrap;
        end
    end

    // one pending correction is consumed by the next crystal count;
    // a new correction wins over a consumption in the same cycle
    always_ff @(posedge clk_sys) begin
        if (reset || trim_magnitude == 3'd0) begin
            trim_pending <= 1'b0;
        end else if (trim_due) begin
            trim_pending <= 1'b1;
        end else if (xtal_tick) begin
            trim_pending <= 1'b0;
        end
    end

    // summer-time comparison
    assign summer_time_enable = summer_start_month_reg[ENABLE_BIT];
    assign start_setting = '{month:   {1'b0, summer_start_month_reg[6:0]},
                             weekday: summer_start_weekday_reg,
                             date:    summer_start_date_reg,
                             hour:    summer_start_hour_reg};
    assign end_setting   = '{month:   summer_end_month_reg,
                             weekday: summer_end_weekday_reg,
                             date:    summer_end_date_reg,
                             hour:    summer_end_hour_reg};

    // both settings are compared every cycle; only a rollover acts on them
    dst_match start_cmp (
        .now     (now),
        .setting (start_setting),
        .hit     (start_hit)
    );

    dst_match end_cmp (
        .now     (now),
        .setting (end_setting),
        .hit     (end_hit)
    );

    // the done flags stop the end jump from firing again when the hour
    // comes round a second time after stepping back
    assign start_fire = hour_rollover && summer_time_enable && start_hit && !start_done;
    // forward wins when both settings match the same hour
    assign end_fire   = hour_rollover && summer_time_enable && end_hit && !end_done
                        && !start_fire;

    always_ff @(posedge clk_sys) begin
        if (reset || now.month != start_setting.month) begin
            start_done <= 1'b0;
        end else if (start_fire) begin
            start_done <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || now.month != end_setting.month) begin
            end_done <= 1'b0;
        end else if (end_fire) begin
            end_done <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dst_step_forward <= 1'b0;
            dst_step_back    <= 1'b0;
        end else begin
            dst_step_forward <= start_fire;
            dst_step_back    <= end_fire;
        end
    end
endmodule // rtc_trim_dst_control

// ===== rtc_trim_dst_properties.sv
// port assertions for the trim, mains check and summer-time block
`timescale 1ns/1ps
module rtc_trim_dst_properties (
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       hour_rollover,
    input wire logic [1:0] mains_qual_period_select,
    input wire logic       mains_qual_fail,
    input wire logic       qual_done,
    input wire logic       dst_step_forward,
    input wire logic       dst_step_back
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_unmapped_reads_zero: assert property (reg_read && (reg_addr < 8'h14 || reg_addr > 8'h1c)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("read data moved");
    a_month_mask: assert property (reg_read && reg_addr == 8'h15 |=> reg_rdata[6:5] == 2'h0)
        else $error("month unused bits set");
    a_hour_mask: assert property (reg_read && reg_addr == 8'h18 |=> !reg_rdata[6])
        else $error("hour bit six set");
    a_step_pulse: assert property (dst_step_forward |=> !dst_step_forward && !dst_step_back)
        else $error("step held");
    a_step_cause: assert property (dst_step_forward || dst_step_back |-> $past(hour_rollover))
        else $error("step without hour change");
    a_fail_at_close: assert property ($changed(mains_qual_fail) |-> qual_done
        || mains_qual_period_select == 2'h0 || $past(mains_qual_period_select) == 2'h0)
        else $error("fail moved outside close");
    a_done_pulse: assert property (qual_done |=> !qual_done)
        else $error("done held");
endmodule // rtc_trim_dst_properties
bind rtc_trim_dst_control rtc_trim_dst_properties u_props (.clk_sys, .reset, .reg_addr,
    .reg_read, .reg_rdata, .hour_rollover, .mains_qual_period_select, .mains_qual_fail,
    .qual_done, .dst_step_forward, .dst_step_back);

// ===== host_model.sv
// register host and pin source in front of the block
`timescale 1ns/1ps
module host_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] reg_rdata,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_write,
    output logic            reg_read,
    output logic            xtal_clk_pin,
    output logic            ac_in_pin
);
    logic [2:0] div;
    // crystal at clk_sys/8, not its true rate, so windows stay short
    always @(posedge clk_sys) div <= div + 3'h1;
    assign xtal_clk_pin = div[2];
    initial begin
        {div, reg_addr, reg_wdata, reg_write, reg_read, ac_in_pin} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    // one mains period of n crystal periods, ending on a rising edge
    task automatic ac_cycles(input int n);
        repeat (n / 2) @(posedge xtal_clk_pin);
        ac_in_pin <= 1'b0;
        repeat (n - n / 2) @(posedge xtal_clk_pin);
        ac_in_pin <= 1'b1;
    endtask
endmodule // host_model

// ===== rtc_trim_dst_control_tb.sv
// self-checking bench for the trim, mains check and summer-time block
`timescale 1ns/1ps
module rtc_trim_dst_control_tb
    import rtc_trim_dst_pkg::*;
;
    logic         clk_sys, reset, reg_write, reg_read, xtal_clk_pin, ac_in_pin;
    logic         hour_rollover, line_freq_select, mains_min_level_select;
    logic         mains_qual_fail, qual_done, second_tick, dst_step_forward, dst_step_back;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata, d;
    logic [1:0]   mains_error_budget_select, mains_qual_period_select;
    rtc_time_type now;
    int           n_errors = 0, n_tests = 0, cyc = 0;
    localparam logic [7:0] RST [9] = '{8'h00, 8'h04, 8'h00, 8'h01, 8'h02, 8'h10, 8'h00, 8'h01, 8'h02};
    localparam logic [7:0] MSK [9] = '{8'h1f, 8'h9f, 8'h7f, 8'h3f, 8'hbf, 8'h1f, 8'h7f, 8'h3f, 8'hbf};
    // fail, 50 Hz, budget code, crystal periods in the window
    localparam logic [15:0] QUAL [8] = '{16'h2222, 16'ha225, 16'h3223, 16'hb226,
        16'h1223, 16'h8225, 16'h628f, 16'he222};
    rtc_trim_dst_control DUT (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .mains_error_budget_select, .mains_qual_period_select, .line_freq_select,
        .xtal_clk_pin, .ac_in_pin, .now, .hour_rollover, .mains_min_level_select,
        .mains_qual_fail, .qual_done, .second_tick, .dst_step_forward, .dst_step_back);
    host_model host (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .xtal_clk_pin, .ac_in_pin);
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic test_regs();
        logic [7:0] a;
        for (int i = 0; i < 9; i++) begin
            a = 8'h14 + 8'(i);
            host.rd(a, d);
            check(d, RST[i]);
            host.wr(a, 8'hff);
            host.rd(a, d);
            check(d, MSK[i]);
            if (i == 0) check({7'h0, mains_min_level_select}, 8'h01);
            host.wr(a, RST[i]);
        end
        host.wr(8'h1d, 8'h5a);
        host.rd(8'h1d, d);
        check(d, 8'h00);
        check({7'h0, mains_min_level_select}, 8'h00);
        $display("test regs done");
    endtask
    task automatic roll(input logic [7:0] fwd, input logic [7:0] back);
        @(posedge clk_sys);
        hour_rollover <= 1'b1;
        @(posedge clk_sys);
        hour_rollover <= 1'b0;
        @(negedge clk_sys);
        check({7'h0, dst_step_forward}, fwd);
        check({7'h0, dst_step_back}, back);
    endtask
    task automatic test_summer();
        host.wr(8'h15, 8'h84);
        @(posedge clk_sys) now <= '{8'h04, 8'h01, 3'h0, 8'h02};
        roll(8'h01, 8'h00);
        roll(8'h00, 8'h00);
        @(posedge clk_sys) now <= '{8'h10, 8'h01, 3'h0, 8'h02};
        roll(8'h00, 8'h01);
        @(posedge clk_sys) now <= '{8'h04, 8'h08, 3'h0, 8'h02};
        roll(8'h00, 8'h00);
        host.wr(8'h16, 8'h50);
        roll(8'h01, 8'h00);
        $display("test summer done");
    endtask
    task automatic test_mains();
        logic [15:0] q;
        @(posedge clk_sys) mains_qual_period_select <= 2'h1;
        host.ac_cycles(546);
        for (int i = 0; i < 8; i++) begin
            q = QUAL[i];
            @(posedge clk_sys);
            line_freq_select <= q[14];
            mains_error_budget_select <= q[13:12];
            host.ac_cycles(int'(q[11:0]));
            for (int k = 0; k < 8 && qual_done !== 1'b1; k++) @(negedge clk_sys);
            check({6'h0, qual_done, mains_qual_fail}, {7'h1, q[15]});
        end
        @(posedge clk_sys) mains_qual_period_select <= 2'h2;
        mains_error_budget_select <= 2'h0;
        repeat (4) host.ac_cycles(656);
        host.ac_cycles(658);
        repeat (4) @(negedge clk_sys);
        check({6'h0, qual_done, mains_qual_fail}, 8'h02);
        $display("test mains done");
    endtask
    initial begin
        reset = 1'b1;
        hour_rollover = 1'b0;
        now = '0;
        {line_freq_select, mains_error_budget_select, mains_qual_period_select} = '0;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        test_regs();
        test_summer();
        test_mains();
        print_verdict();
    end
endmodule // rtc_trim_dst_control_tb
